// File: hdl/tcer_pkg.sv
`default_nettype none
package tcer_pkg;
  // register offsets
  localparam logic [7:0] OFS_OUTPUT_VALUE_OVERRIDE = 8'h02;
  localparam logic [7:0] OFS_SPLIT_SELECT          = 8'h03;
  localparam logic [7:0] OFS_COMMAND_DIR_CLEAR     = 8'h04;
  localparam logic [7:0] OFS_COMMAND_DIR_SET       = 8'h05;
  localparam logic [7:0] OFS_BUFFER_VALID_CLEAR    = 8'h06;
  localparam logic [7:0] OFS_BUFFER_VALID_SET      = 8'h07;
  localparam logic [7:0] OFS_EVENT_INPUT_CONTROL   = 8'h09;
  localparam logic [7:0] OFS_INTERRUPT_ENABLE      = 8'h0A;
  // reset value shared by every register
  localparam logic [7:0] REG_RESET = 8'h00;
  // field positions
  localparam int DIR_BIT      = 0;
  localparam int LOCK_BIT     = 1;
  localparam int CMD_LSB      = 2;
  localparam int SPLIT_BIT    = 0;
  localparam int EVA_EN_BIT   = 0;
  localparam int EVA_ACT_LSB  = 1;
  localparam int EVB_EN_BIT   = 4;
  localparam int EVB_ACT_LSB  = 5;
  localparam int IEN_WRAP_BIT = 0;
  localparam int IEN_CMP_LSB  = 4;
  localparam int NUM_CHAN     = 3;
  // field masks of implemented bits
  localparam logic [7:0] MASK_OVERRIDE = 8'h07;
  localparam logic [7:0] MASK_SPLIT    = 8'h01;
  localparam logic [7:0] MASK_CMDDIR   = 8'h03;
  localparam logic [7:0] MASK_BUFVALID = 8'h0F;
  localparam logic [7:0] MASK_IEN      = 8'h71;
  // command codes
  localparam logic [1:0] CMD_NONE    = 2'h0;
  localparam logic [1:0] CMD_UPDATE  = 2'h1;
  localparam logic [1:0] CMD_RESTART = 2'h2;
  localparam logic [1:0] CMD_RESET   = 2'h3;
  // event action codes
  localparam logic [2:0] EVA_COUNT_RISING      = 3'h0;
  localparam logic [2:0] EVA_COUNT_BOTH_EDGES  = 3'h1;
  localparam logic [2:0] EVA_COUNT_WHILE_HIGH  = 3'h2;
  localparam logic [2:0] EVA_EVENT_DIRECTION_CONTROL            = 3'h3;
  localparam logic [2:0] EVB_NONE              = 3'h0;
  localparam logic [2:0] EVB_EVENT_DIRECTION_CONTROL            = 3'h3;
  localparam logic [2:0] EVB_RESTART_RISING    = 3'h4;
  localparam logic [2:0] EVB_RESTART_BOTH      = 3'h5;
  localparam logic [2:0] EVB_RESTART_HIGH      = 3'h6;
endpackage : tcer_pkg
`default_nettype wire

// File: hdl/tcer_setclr.sv
`default_nettype none
// one clear/set register pair; hardware set and clear arrive as masks
module tcer_setclr #(
  parameter int WIDTH = 4
) (
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] sw_clr_in,
  input  wire logic [WIDTH-1:0] sw_set_in,
  input  wire logic [WIDTH-1:0] hw_clr_in,
  input  wire logic [WIDTH-1:0] hw_set_in,
  output logic      [WIDTH-1:0] bits_out
);
  typedef struct packed {
    logic [WIDTH-1:0] bits;
  } tcer_sc_s;
  tcer_sc_s st_q;
  tcer_sc_s st_d;

  // hardware set wins over any clear so no fresh event is lost
  always_comb begin
    st_d      = st_q;
    st_d.bits = ((st_q.bits & ~sw_clr_in & ~hw_clr_in) | sw_set_in) | hw_set_in;  // [RULE3]
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign bits_out = st_q.bits;
endmodule : tcer_setclr
`default_nettype wire

// File: hdl/tcer_edge.sv
`default_nettype none
// rising and any-edge detection of one event line
module tcer_edge (
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  input  wire logic level_in,
  output logic      rise_out,
  output logic      any_out
);
  typedef struct packed {
    logic prev;
  } tcer_edge_s;
  tcer_edge_s st_q;
  tcer_edge_s st_d;

  always_comb begin
    st_d      = st_q;
    st_d.prev = level_in;
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // combinational so the caller registers once; events are synchronous already
  assign rise_out = level_in & ~st_q.prev;
  assign any_out  = level_in ^ st_q.prev;
endmodule : tcer_edge
`default_nettype wire

// File: hdl/tcer_regs.sv
`default_nettype none
// Contract
// [RULE1] stopped timer: override bits drive waveform levels
// [RULE2] split bit selects dual eight-bit mode
// [RULE3] clear/set pairs: ones clear or set
// [RULE4] command 1 update, 2 restart, 3 reset
// [RULE5] command bits always read zero
// [RULE6] hard reset ignored while timer enabled
// [RULE7] lock one: no buffer transfer
// [RULE8] lock zero: transfer on update condition
// [RULE9] direction zero up, one down
// [RULE10] direction set by hardware, software overrides
// [RULE11] compare buffer write sets channel fresh flag
// [RULE12] period buffer write sets period flag
// [RULE13] update condition clears all fresh flags
// [RULE14] event A action decode, others reserved
// [RULE15] event B action decode, others reserved
// [RULE16] up/down: low counts up, high down
// [RULE17] event A acts only when enabled
// [RULE18] event B acts only when enabled
// [RULE19] compare irq forwarded only when enabled
// [RULE20] wrap irq forwarded only when enabled
// [RULE21] update copies compare buffers, lock permitting
// [RULE22] match and wrap flags cleared by software one; here flag_clr and wrap_clr are tied to zero, so the flags never clear
// [RULE23] auto lock holds until enabled buffers fresh
// [RULE24] both registers of a pair read same
module tcer_regs #(
  parameter int NCH = tcer_pkg::NUM_CHAN
) (
  input  wire logic           clock_in,
  input  wire logic           rst_n_in,
  // register port
  input  wire logic [7:0]     addr_in,
  input  wire logic [7:0]     wdata_in,
  input  wire logic           wr_in,
  input  wire logic           rd_in,
  output logic      [7:0]     rdata_out,
  // timer state from the datapath
  input  wire logic           timer_enable_in,
  input  wire logic           auto_update_lock_in,
  input  wire logic [NCH-1:0] chan_enable_in,
  input  wire logic           update_cond_in,
  input  wire logic           hw_dir_valid_in,
  input  wire logic           hw_dir_in,
  input  wire logic           period_buffer_wr_in,
  input  wire logic [NCH-1:0] compare_buffer_wr_in,
  input  wire logic [NCH-1:0] cmp_match_in,
  input  wire logic           wrap_in,
  input  wire logic [NCH-1:0] wg_level_in,
  input  wire logic           event_a_in,
  input  wire logic           event_b_in,
  // controls toward the datapath
  output logic [NCH-1:0]      waveform_pin_output_out,
  output logic                dual_8bit_select_out,
  output logic                count_down_out,
  output logic                transfer_out,
  output logic                restart_out,
  output logic                hard_reset_out,
  output logic                count_step_out,
  output logic                event_count_gate_out,
  output logic [NCH-1:0]      cmp_irq_out,
  output logic                wrap_irq_out
);
  typedef struct packed {
    logic [7:0]     rdata;
    logic [NCH-1:0] forced_level;
    logic           dual_8bit_select;
    logic           dir;
    logic           update_lock;
    logic [7:0]     event_ctrl;
    logic [7:0]     int_enable;
    logic [NCH-1:0] wave;
    logic           transfer;
    logic           restart;
    logic           hard_reset;
    logic           count_step;
    logic           count_gate;
    logic           auto_lock_armed;
    logic [NCH-1:0] cmp_irq;
    logic           wrap_irq;
  } tcer_regs_s;

  tcer_regs_s st_q;
  tcer_regs_s st_d;

  logic [3:0] buf_sw_clr;
  logic [3:0] buf_sw_set;
  logic [3:0] buf_hw_set;
  logic [3:0] buf_hw_clr;
  logic [3:0] buf_fresh;
  logic       a_rise;
  logic       a_any;
  logic       b_rise;
  logic       b_any;
  logic [NCH-1:0] cmp_flag;
  logic           wrap_flag;
  logic [NCH-1:0] flag_clr;
  logic           wrap_clr;

  // buffer fresh flags: software pair plus hardware set/clear
  assign buf_sw_clr = (wr_in && addr_in == tcer_pkg::OFS_BUFFER_VALID_CLEAR) ?
                      wdata_in[3:0] : 4'h0;  // [RULE3]
  assign buf_sw_set = (wr_in && addr_in == tcer_pkg::OFS_BUFFER_VALID_SET) ?
                      wdata_in[3:0] : 4'h0;  // [RULE3]
  assign buf_hw_set = {compare_buffer_wr_in, period_buffer_wr_in};  // [RULE11] [RULE12]
  assign buf_hw_clr = update_cond_in ? 4'hF : 4'h0;  // [RULE13]

  tcer_setclr #(
    .WIDTH (4)
  ) u_buf_fresh (
    .clock_in  (clock_in),
    .rst_n_in  (rst_n_in),
    .sw_clr_in (buf_sw_clr),
    .sw_set_in (buf_sw_set),
    .hw_clr_in (buf_hw_clr),
    .hw_set_in (buf_hw_set),
    .bits_out  (buf_fresh)
  );

  // match and wrap flags: sticky, with the software clear inputs tied to zero
  assign flag_clr = '0;
  assign wrap_clr = 1'b0;
  tcer_setclr #(
    .WIDTH (NCH + 1)
  ) u_flags (
    .clock_in  (clock_in),
    .rst_n_in  (rst_n_in),
    .sw_clr_in ({flag_clr, wrap_clr}),  // [RULE22]
    .sw_set_in ('0),
    .hw_clr_in ('0),
    .hw_set_in ({cmp_match_in, wrap_in}),  // [RULE22]
    .bits_out  ({cmp_flag, wrap_flag})
  );

  tcer_edge u_edge_a (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .level_in (event_a_in),
    .rise_out (a_rise),
    .any_out  (a_any)
  );

  tcer_edge u_edge_b (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .level_in (event_b_in),
    .rise_out (b_rise),
    .any_out  (b_any)
  );

  always_comb begin
    logic [1:0] cmd;
    logic       cmd_wr;
    logic       upd;
    logic [2:0] act_a;
    logic [2:0] act_b;
    logic       en_a;
    logic       en_b;
    logic [NCH-1:0] ch_ok;
    cmd    = 2'h0;
    cmd_wr = 1'b0;
    upd    = 1'b0;
    ch_ok  = '0;
    st_d   = st_q;
    act_a  = st_q.event_ctrl[tcer_pkg::EVA_ACT_LSB +: 3];
    act_b  = st_q.event_ctrl[tcer_pkg::EVB_ACT_LSB +: 3];
    en_a   = st_q.event_ctrl[tcer_pkg::EVA_EN_BIT];
    en_b   = st_q.event_ctrl[tcer_pkg::EVB_EN_BIT];
    st_d.transfer   = 1'b0;
    st_d.restart    = 1'b0;
    st_d.hard_reset = 1'b0;
    st_d.count_step = 1'b0;
    st_d.count_gate = 1'b0;

    // register writes: plain read/write registers and the command/direction clear/set pair
    if (wr_in) begin
      unique case (addr_in)
        tcer_pkg::OFS_OUTPUT_VALUE_OVERRIDE: st_d.forced_level = wdata_in[NCH-1:0];
        tcer_pkg::OFS_SPLIT_SELECT: begin
          st_d.dual_8bit_select = wdata_in[tcer_pkg::SPLIT_BIT];  // [RULE2]
        end
        tcer_pkg::OFS_EVENT_INPUT_CONTROL: st_d.event_ctrl = wdata_in;
        tcer_pkg::OFS_INTERRUPT_ENABLE: st_d.int_enable = wdata_in & tcer_pkg::MASK_IEN;
        tcer_pkg::OFS_COMMAND_DIR_CLEAR: begin
          if (wdata_in[tcer_pkg::DIR_BIT]) st_d.dir = 1'b0;  // [RULE3]
          if (wdata_in[tcer_pkg::LOCK_BIT]) st_d.update_lock = 1'b0;  // [RULE3]
          cmd    = wdata_in[tcer_pkg::CMD_LSB +: 2];
          cmd_wr = 1'b1;
        end
        tcer_pkg::OFS_COMMAND_DIR_SET: begin
          if (wdata_in[tcer_pkg::DIR_BIT]) st_d.dir = 1'b1;  // [RULE3]
          if (wdata_in[tcer_pkg::LOCK_BIT]) st_d.update_lock = 1'b1;  // [RULE3]
          cmd    = wdata_in[tcer_pkg::CMD_LSB +: 2];
          cmd_wr = 1'b1;
        end
        default: ;
      endcase
    end

    // hardware direction from waveform mode, unless software just wrote it
    if (hw_dir_valid_in && !(cmd_wr && wdata_in[tcer_pkg::DIR_BIT])) begin
      st_d.dir = hw_dir_in;  // [RULE10]
    end

    // command decode; hard reset only honoured while stopped
    if (cmd_wr) begin
      unique case (cmd)
        tcer_pkg::CMD_NONE:    ;
        tcer_pkg::CMD_UPDATE:  upd = 1'b1;  // [RULE4]
        tcer_pkg::CMD_RESTART: st_d.restart = 1'b1;  // [RULE4]
        tcer_pkg::CMD_RESET:   st_d.hard_reset = !timer_enable_in;  // [RULE4] [RULE6]
      endcase
    end

    // event input A
    if (en_a) begin  // [RULE17]
      unique case (act_a)
        tcer_pkg::EVA_COUNT_RISING:     st_d.count_step = a_rise;  // [RULE14]
        tcer_pkg::EVA_COUNT_BOTH_EDGES: st_d.count_step = a_any;  // [RULE14]
        tcer_pkg::EVA_COUNT_WHILE_HIGH: st_d.count_gate = event_a_in;  // [RULE14]
        tcer_pkg::EVA_EVENT_DIRECTION_CONTROL: begin
          st_d.count_gate = 1'b1;
          st_d.dir        = event_a_in;  // [RULE16] [RULE9]
        end
        default: ;  // reserved codes do nothing
      endcase
    end

    // event input B
    if (en_b) begin  // [RULE18]
      unique case (act_b)
        tcer_pkg::EVB_NONE:           ;
        tcer_pkg::EVB_EVENT_DIRECTION_CONTROL:         st_d.dir = event_b_in;  // [RULE15] [RULE16]
        tcer_pkg::EVB_RESTART_RISING: st_d.restart = st_d.restart | b_rise;  // [RULE15]
        tcer_pkg::EVB_RESTART_BOTH:   st_d.restart = st_d.restart | b_any;  // [RULE15]
        tcer_pkg::EVB_RESTART_HIGH:   st_d.restart = st_d.restart | event_b_in;  // [RULE15]
        default: ;
      endcase
    end

    // transfer gated by the lock as it stood before this cycle
    upd = upd | update_cond_in;
    st_d.transfer = upd & ~st_q.update_lock;  // [RULE7] [RULE8] [RULE21]

    // auto lock: release once every enabled channel buffer is fresh
    ch_ok = buf_fresh[NCH:1] | ~chan_enable_in;
    if (auto_update_lock_in) begin
      if (!st_q.auto_lock_armed) begin
        st_d.update_lock     = 1'b1;  // [RULE23]
        st_d.auto_lock_armed = 1'b1;
      end else if (st_q.transfer) begin
        st_d.update_lock = 1'b1;  // [RULE23]
      end else if (&ch_ok) begin
        st_d.update_lock = 1'b0;  // [RULE23]
      end
    end else begin
      st_d.auto_lock_armed = 1'b0;
    end

    // waveform levels forced while stopped
    st_d.wave = timer_enable_in ? wg_level_in : st_q.forced_level;  // [RULE1]

    // interrupt forwarding
    st_d.wrap_irq = wrap_flag & st_q.int_enable[tcer_pkg::IEN_WRAP_BIT];  // [RULE20]
    st_d.cmp_irq  = cmp_flag & st_q.int_enable[tcer_pkg::IEN_CMP_LSB +: NCH];  // [RULE19]

    // read data, valid only in the cycle after the strobe
    st_d.rdata = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        tcer_pkg::OFS_OUTPUT_VALUE_OVERRIDE: st_d.rdata = {5'h00, st_q.forced_level};
        tcer_pkg::OFS_SPLIT_SELECT:          st_d.rdata = {7'h00, st_q.dual_8bit_select};
        tcer_pkg::OFS_COMMAND_DIR_CLEAR,
        tcer_pkg::OFS_COMMAND_DIR_SET:
          st_d.rdata = {6'h00, st_q.update_lock, st_q.dir};  // [RULE5] [RULE24]
        tcer_pkg::OFS_BUFFER_VALID_CLEAR,
        tcer_pkg::OFS_BUFFER_VALID_SET:      st_d.rdata = {4'h0, buf_fresh};  // [RULE24]
        tcer_pkg::OFS_EVENT_INPUT_CONTROL:   st_d.rdata = st_q.event_ctrl;
        tcer_pkg::OFS_INTERRUPT_ENABLE:      st_d.rdata = st_q.int_enable;
        default:                             st_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // every output comes from the state register
  assign rdata_out               = st_q.rdata;
  assign waveform_pin_output_out = st_q.wave;
  assign dual_8bit_select_out    = st_q.dual_8bit_select;
  assign count_down_out          = st_q.dir;  // [RULE9]
  assign transfer_out            = st_q.transfer;
  assign restart_out             = st_q.restart;
  assign hard_reset_out          = st_q.hard_reset;
  assign count_step_out          = st_q.count_step;
  assign event_count_gate_out    = st_q.count_gate;
  assign cmp_irq_out             = st_q.cmp_irq;
  assign wrap_irq_out            = st_q.wrap_irq;
endmodule : tcer_regs
`default_nettype wire

// File: verif/tcer_regs_checker.sv
`default_nettype none
module tcer_regs_checker #(
  parameter int NCH = 3
) (
  input wire logic           clock_in,
  input wire logic           rst_n_in,
  input wire logic [7:0]     addr_in,
  input wire logic [7:0]     wdata_in,
  input wire logic           wr_in,
  input wire logic           rd_in,
  input wire logic [7:0]     rdata_out,
  input wire logic           timer_enable_in,
  input wire logic           auto_update_lock_in,
  input wire logic           update_cond_in,
  input wire logic           dual_8bit_select_out,
  input wire logic           count_down_out,
  input wire logic           transfer_out,
  input wire logic           restart_out,
  input wire logic           hard_reset_out,
  input wire logic [NCH-1:0] cmp_irq_out,
  input wire logic           wrap_irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  logic [7:0] ien_q;
  logic       lk_q;
  logic       stale_q;
  logic       w05;
  assign w05 = wr_in && addr_in == 8'h05;
  // mirrors of enables and lock; auto-lock takes the lock out of software's hands
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ien_q   <= 8'h00;
      lk_q    <= 1'b0;
      stale_q <= 1'b0;
    end else begin
      if (wr_in && addr_in == 8'h0A) ien_q <= wdata_in;
      if (w05 && wdata_in[1]) lk_q <= 1'b1;
      if (wr_in && addr_in == 8'h04 && wdata_in[1]) lk_q <= 1'b0;
      if (auto_update_lock_in) stale_q <= 1'b1;
    end
  end
  sequence s_cmd(logic [1:0] c);
    w05 && wdata_in[3:2] == c;
  endsequence
  sequence s_upd;
    (update_cond_in || (w05 && wdata_in[3:2] == 2'h1)) && !stale_q;
  endsequence
  a_cmd_readzero: assert property (
    rd_in && addr_in inside {8'h04, 8'h05} |=> rdata_out[3:2] == 2'h0)
    else $error("command bits read back nonzero");
  a_hard_ignored: assert property (s_cmd(2'h3) ##0 timer_enable_in |=> !hard_reset_out)
    else $error("hard reset while running");
  a_hard_taken: assert property (s_cmd(2'h3) ##0 !timer_enable_in |=> hard_reset_out)
    else $error("hard reset command lost");
  a_restart_cmd: assert property (s_cmd(2'h2) |=> restart_out)
    else $error("restart command lost");
  a_update_xfer: assert property (
    s_upd |=> transfer_out == !$past(lk_q))
    else $error("transfer disagrees with lock");
  a_split_follow: assert property (
    wr_in && addr_in == 8'h03 |=> dual_8bit_select_out == $past(wdata_in[0]))
    else $error("split select wrong");
  a_dir_write: assert property (
    wr_in && addr_in inside {8'h04, 8'h05} && wdata_in[0] |=> count_down_out == $past(addr_in[0]))
    else $error("direction write wrong");
  a_cmp_gate: assert property (
    !stale_q |-> (cmp_irq_out & ~(ien_q[4+:NCH] | $past(ien_q[4+:NCH]))) == '0)
    else $error("compare irq without enable");
  a_wrap_gate: assert property (
    !stale_q && wrap_irq_out |-> ien_q[0] || $past(ien_q[0]))
    else $error("wrap irq without enable");
endmodule : tcer_regs_checker
bind tcer_regs tcer_regs_checker #(.NCH(NCH)) chk_u (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .timer_enable_in(timer_enable_in), .auto_update_lock_in(auto_update_lock_in),
  .update_cond_in(update_cond_in), .dual_8bit_select_out(dual_8bit_select_out),
  .count_down_out(count_down_out), .transfer_out(transfer_out), .restart_out(restart_out),
  .hard_reset_out(hard_reset_out), .cmp_irq_out(cmp_irq_out), .wrap_irq_out(wrap_irq_out));
`default_nettype wire

// File: verif/tcer_regs_bench.sv
`default_nettype none
module tcer_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock_in, rst_n_in, wr_in, rd_in, timer_enable_in, auto_update_lock_in;
  logic       update_cond_in, hw_dir_valid_in, hw_dir_in, period_buffer_wr_in, wrap_in;
  logic       event_a_in, event_b_in, dual_8bit_select_out, count_down_out, transfer_out;
  logic       restart_out, hard_reset_out, count_step_out, event_count_gate_out, wrap_irq_out;
  logic [7:0] addr_in, wdata_in, rdata_out;
  logic [2:0] chan_enable_in, compare_buffer_wr_in, cmp_match_in, wg_level_in;
  logic [2:0] waveform_pin_output_out, cmp_irq_out;
  int         err_total, n_compared;
  logic [7:0] ofs [4] = '{8'h02, 8'h03, 8'h09, 8'h0A};
  logic [7:0] msk [4] = '{8'h07, 8'h01, 8'hFF, 8'h71};
  logic [7:0] cexp [4] = '{8'h00, 8'h01, 8'h02, 8'h04};
  tcer_regs dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .timer_enable_in(timer_enable_in), .auto_update_lock_in(auto_update_lock_in),
    .chan_enable_in(chan_enable_in), .update_cond_in(update_cond_in),
    .hw_dir_valid_in(hw_dir_valid_in), .hw_dir_in(hw_dir_in),
    .period_buffer_wr_in(period_buffer_wr_in), .compare_buffer_wr_in(compare_buffer_wr_in),
    .cmp_match_in(cmp_match_in), .wrap_in(wrap_in), .wg_level_in(wg_level_in),
    .event_a_in(event_a_in), .event_b_in(event_b_in),
    .waveform_pin_output_out(waveform_pin_output_out),
    .dual_8bit_select_out(dual_8bit_select_out), .count_down_out(count_down_out),
    .transfer_out(transfer_out), .restart_out(restart_out), .hard_reset_out(hard_reset_out),
    .count_step_out(count_step_out), .event_count_gate_out(event_count_gate_out),
    .cmp_irq_out(cmp_irq_out), .wrap_irq_out(wrap_irq_out));
  // free-running clock, 10 ns period
  always #5 clock_in = ~clock_in;
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task end_sim;
    if (err_total == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task tick;
    @(posedge clock_in);
    #1;
  endtask : tick
  // one-cycle write; the strobe drops after the capturing edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    tick();
    wr_in <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    tick();
    rd_in <= 1'b0;
    chk(rdata_out, e);
  endtask : rc
  // one-cycle pulse on a datapath input, selected by k
  task pulse(input int k, input logic [2:0] v);
    @(posedge clock_in);
    case (k)
      0: update_cond_in <= 1'b1;
      1: period_buffer_wr_in <= 1'b1;
      2: compare_buffer_wr_in <= v;
      3: cmp_match_in <= v;
      4: wrap_in <= 1'b1;
      default: hw_dir_valid_in <= 1'b1;
    endcase
    tick();
    {update_cond_in, period_buffer_wr_in, compare_buffer_wr_in} <= 5'h00;
    {cmp_match_in, wrap_in, hw_dir_valid_in} <= 5'h00;
  endtask : pulse
  function automatic logic sig(input int k);
    case (k)
      0: return count_down_out;
      1: return restart_out;
      default: return count_step_out;
    endcase
  endfunction : sig
  // event paths register once behind a combinational edge detector, so the latency is one cycle; seek waits up to 8
  task seek(input int k, input logic e, input bit stay);
    for (int i = 0; i < 8; i++) begin
      if (!stay && sig(k) === e) break;
      tick();
      if (stay) chk(sig(k), e);
    end
    if (!stay) chk(sig(k), e);
  endtask : seek
  initial begin
    #100us;
    err_total++;
    end_sim();
  end
  initial begin
    {clock_in, rst_n_in, wr_in, rd_in, timer_enable_in, auto_update_lock_in} = 6'h00;
    {update_cond_in, hw_dir_valid_in, hw_dir_in, period_buffer_wr_in, wrap_in} = 5'h00;
    {event_a_in, event_b_in, addr_in, wdata_in} = 18'h00000;
    {chan_enable_in, compare_buffer_wr_in, cmp_match_in, wg_level_in} = 12'h000;
    err_total  = 0;
    n_compared = 0;
    repeat (8) @(posedge clock_in);
    rst_n_in <= 1'b1;
    // reset values, implemented bits, unmapped place
    for (int i = 0; i < 4; i++) begin
      rc(ofs[i], 8'h00);
      wr(ofs[i], 8'hFF);
      rc(ofs[i], msk[i]);
      wr(ofs[i], 8'h00);
    end
    wr(8'h08, 8'hFF);
    rc(8'h08, 8'h00);
    // sticky flags reach the irq lines only through their enables
    pulse(3, 3'h5);
    pulse(4, 3'h0);
    chk({4'h0, cmp_irq_out, wrap_irq_out}, 8'h00);
    wr(8'h0A, 8'h11);
    tick();
    chk({4'h0, cmp_irq_out, wrap_irq_out}, 8'h03);
    wr(8'h0A, 8'h71);
    tick();
    chk({4'h0, cmp_irq_out, wrap_irq_out}, 8'h0B);
    // lock blocks a transfer, unlocked transfers at once
    wr(8'h05, 8'h02);
    rc(8'h04, 8'h02);
    pulse(0, 3'h0);
    chk(transfer_out, 8'h00);
    wr(8'h04, 8'h02);
    pulse(0, 3'h0);
    chk(transfer_out, 8'h01);
    // fresh flags
    pulse(1, 3'h0);
    rc(8'h06, 8'h01);
    pulse(2, 3'h5);
    rc(8'h07, 8'h0B);
    wr(8'h06, 8'h01);
    rc(8'h07, 8'h0A);
    wr(8'h07, 8'h04);
    rc(8'h06, 8'h0E);
    pulse(0, 3'h0);
    rc(8'h06, 8'h00);
    // direction by software and by hardware
    wr(8'h05, 8'h01);
    chk(count_down_out, 8'h01);
    wr(8'h04, 8'h01);
    chk(count_down_out, 8'h00);
    hw_dir_in <= 1'b1;
    pulse(5, 3'h0);
    seek(0, 1'b1, 1'b0);
    wr(8'h04, 8'h01);
    chk(count_down_out, 8'h00);
    // every command code while stopped, then hard reset while running
    for (int c = 0; c < 4; c++) begin
      wr(8'h05, 8'(c << 2));
      chk({hard_reset_out, restart_out, transfer_out}, cexp[c]);
      rc(8'h05, 8'h00);
    end
    timer_enable_in <= 1'b1;
    wr(8'h05, 8'h0C);
    chk(hard_reset_out, 8'h00);
    // forced levels only while stopped
    timer_enable_in <= 1'b0;
    wg_level_in     <= 3'h2;
    wr(8'h02, 8'h05);
    tick();
    chk(waveform_pin_output_out, 8'h05);
    timer_enable_in <= 1'b1;
    tick();
    tick();
    chk(waveform_pin_output_out, 8'h02);
    wr(8'h03, 8'h01);
    chk(dual_8bit_select_out, 8'h01);
    // every event action code, reserved ones too, reads back
    for (int i = 0; i < 8; i++) begin
      wr(8'h09, 8'(i * 8'h22 + 8'h11));
      rc(8'h09, 8'(i * 8'h22 + 8'h11));
    end
    wr(8'h09, 8'h07);
    event_a_in <= 1'b1;
    seek(0, 1'b1, 1'b0);
    event_a_in <= 1'b0;
    seek(0, 1'b0, 1'b0);
    wr(8'h09, 8'h06);
    event_a_in <= 1'b1;
    seek(0, 1'b0, 1'b1);
    wr(8'h09, 8'h01);
    event_a_in <= 1'b0;
    tick();
    event_a_in <= 1'b1;
    seek(2, 1'b1, 1'b0);
    wr(8'h09, 8'h03);
    event_a_in <= 1'b0;
    seek(2, 1'b1, 1'b0);
    wr(8'h09, 8'h05);
    event_a_in <= 1'b1;
    tick();
    chk(event_count_gate_out, 8'h01);
    event_a_in <= 1'b0;
    tick();
    chk(event_count_gate_out, 8'h00);
    wr(8'h09, 8'h90);
    event_b_in <= 1'b1;
    seek(1, 1'b1, 1'b0);
    wr(8'h09, 8'hB0);
    event_b_in <= 1'b0;
    seek(1, 1'b1, 1'b0);
    wr(8'h09, 8'hD0);
    event_b_in <= 1'b1;
    seek(1, 1'b1, 1'b0);
    event_b_in <= 1'b0;
    wr(8'h09, 8'hC0);
    event_b_in <= 1'b1;
    seek(1, 1'b0, 1'b1);
    event_b_in <= 1'b0;
    wr(8'h09, 8'h70);
    event_b_in <= 1'b1;
    seek(0, 1'b1, 1'b0);
    event_b_in <= 1'b0;
    wr(8'h09, 8'h00);
    // auto lock: held until enabled channel is fresh, back after the transfer
    chan_enable_in      <= 3'h1;
    auto_update_lock_in <= 1'b1;
    tick();
    rc(8'h05, 8'h02);
    pulse(2, 3'h1);
    tick();
    rc(8'h05, 8'h00);
    pulse(0, 3'h0);
    chk(transfer_out, 8'h01);
    tick();
    rc(8'h05, 8'h02);
    end_sim();
  end
endmodule : tcer_regs_bench
`default_nettype wire
